// [mwrp_consts.vh]
// Purpose: shared constants for the metering waveform and rms path
// Assumes: 10 MHz core clock, converter samples arrive at core clock / 4
// Notes: definitions only
`ifndef MWRP_CONSTS_VH
`define MWRP_CONSTS_VH
// ==========================================================
// register addresses
`define MWRP_ADDR_WAVEFORM 6'h01
`define MWRP_ADDR_MODE 6'h09
`define MWRP_ADDR_IRQ_EN 6'h0a
`define MWRP_ADDR_STATUS 6'h0b
`define MWRP_ADDR_RST_STATUS 6'h0c
`define MWRP_ADDR_CH2_GAIN 6'h0f
`define MWRP_ADDR_CURRENT_RMS_RESULT 6'h16
`define MWRP_ADDR_CURRENT_RMS_OFFSET_TRIM 6'h18
// ==========================================================
// field positions and codes
`define MWRP_MODE_SRC_HI 14
`define MWRP_MODE_SRC_LO 13
`define MWRP_MODE_RATE_HI 12
`define MWRP_MODE_RATE_LO 11
`define MWRP_SRC_CH1 2'h2
`define MWRP_SRC_CH2 2'h3
`define MWRP_WAVEFORM_SAMPLE_IRQ_ENABLE_BIT 3
// ==========================================================
// reset values
`define MWRP_MODE_RST 16'h000c
`define MWRP_IRQ_EN_RST 16'h0000
`define MWRP_CURRENT_RMS_OFFSET_TRIM_RST 12'h000
`define MWRP_GAIN_RST 3'h0
// ==========================================================
// timing: fastest waveform rate is core clock / 128, rms update is core clock / 4
`define MWRP_WAVE_DIV_MIN 11'h080
`define MWRP_RMS_DIV 2'h3
`define MWRP_OFFSET_SCALE 15
`define MWRP_RMS_SHIFT 14
`define MWRP_LPF_HZ 140
`define MWRP_SAMPLE_HZ 2500000
// lpf shift: nearest power of two to fs / (2 pi fc), about 2^11.5
`define MWRP_LPF_SHIFT 11
`endif

// [mwrp_core.v]
// Purpose: channel 1 waveform and rms, channel 2 filtered waveform, host read port
// Assumes: converter samples come from logic on CORE_CLK_IN, one valid pulse each
// Notes: reads return bytes msb first through a two-entry output buffer
`timescale 1ns/1ns
`include "mwrp_consts.vh"

module mwrp_core (
  input wire CORE_CLK_IN,
  input wire RST_IN,
  input wire [23:0] CH1_SAMPLE_IN,
  input wire CH1_VALID_IN,
  input wire [15:0] CH2_SAMPLE_IN,
  input wire CH2_VALID_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [5:0] ADDR_IN,
  input wire [15:0] WDATA_IN,
  input wire BYTE_READY_IN,
  output reg [7:0] BYTE_DATA_OUT,
  output reg BYTE_VALID_OUT,
  output reg BUSY_OUT,
  output reg IRQ_N_OUT,
  output reg [15:0] CH2_MULT_OUT,
  output reg [23:0] CH1_MULT_OUT
);

  // ==========================================================
  // integer square root, one result bit per step
  function [23:0] mwrp_isqrt;
    input [47:0] v;
    reg [23:0] r;
    reg [23:0] trial;
    integer i;
    begin
      r = 24'h000000;
      for (i = 23; i >= 0; i = i - 1)
      begin
        trial = r | (24'h000001 << i);
        if (({24'h000000, trial} * {24'h000000, trial}) <= v)
          r = trial;
      end
      mwrp_isqrt = r;
    end
  endfunction

  // ==========================================================
  // registers
  reg [15:0] mode_r;
  reg [15:0] irq_en_r;
  reg [15:0] status_r;
  reg [15:0] status_nxt;
  reg [11:0] current_rms_offset_trim_r;
  reg [2:0] gain_r;
  reg [23:0] wave_r;
  reg [23:0] current_rms_result_r;
  reg [47:0] msq_r;
  reg [23:0] ch1_last_r;
  reg [23:0] ch2_lpf_r;
  reg [10:0] rate_cnt_r;
  reg [1:0] rms_cnt_r;

  wire [1:0] src = mode_r[`MWRP_MODE_SRC_HI:`MWRP_MODE_SRC_LO];
  wire [1:0] rate_sel = mode_r[`MWRP_MODE_RATE_HI:`MWRP_MODE_RATE_LO];
  wire waveform_sample_irq_enable_en = irq_en_r[`MWRP_WAVEFORM_SAMPLE_IRQ_ENABLE_BIT];

  // ==========================================================
  // write port: software-steered configuration
  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      mode_r <= `MWRP_MODE_RST;
      irq_en_r <= `MWRP_IRQ_EN_RST;
      current_rms_offset_trim_r <= `MWRP_CURRENT_RMS_OFFSET_TRIM_RST;
      gain_r <= `MWRP_GAIN_RST;
    end
    else if (WR_IN)
    begin
      case (ADDR_IN)
        `MWRP_ADDR_MODE: mode_r <= WDATA_IN;
        `MWRP_ADDR_IRQ_EN: irq_en_r <= WDATA_IN;
        `MWRP_ADDR_CURRENT_RMS_OFFSET_TRIM: current_rms_offset_trim_r <= WDATA_IN[11:0];
        `MWRP_ADDR_CH2_GAIN: gain_r <= WDATA_IN[2:0];
        default: gain_r <= gain_r;
      endcase
    end
  end

  // ==========================================================
  // channel 2: gain then split into raw multiplier feed and lowpass
  // gain codes above 4 are held at 16 rather than wrapping
  wire [2:0] gain_eff = (gain_r > 3'h4) ? 3'h4 : gain_r;
  wire [15:0] ch2_gained = CH2_SAMPLE_IN << gain_eff;
  wire [23:0] ch2_ext = {{8{ch2_gained[15]}}, ch2_gained};
  // single pole: y += (x - y) / 2^k, cutoff near 140 Hz at 2.5 MHz
  wire [23:0] lpf_diff = ch2_ext - ch2_lpf_r;
  wire [23:0] lpf_step = {{`MWRP_LPF_SHIFT{lpf_diff[23]}}, lpf_diff[23:`MWRP_LPF_SHIFT]};

  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      ch2_lpf_r <= 24'h000000;
      CH2_MULT_OUT <= 16'h0000;
      CH1_MULT_OUT <= 24'h000000;
    end
    else
    begin
      if (CH2_VALID_IN)
      begin
        ch2_lpf_r <= ch2_lpf_r + lpf_step;
        CH2_MULT_OUT <= ch2_gained;
      end
      if (CH1_VALID_IN)
        CH1_MULT_OUT <= CH1_SAMPLE_IN;
    end
  end

  // ==========================================================
  // channel 1 mean square and rms
  // mean square tracks with a leaky average; short shift trades ripple for settling
  wire [23:0] ch1_abs = CH1_SAMPLE_IN[23] ? (24'h000000 - CH1_SAMPLE_IN) : CH1_SAMPLE_IN;
  wire [47:0] ch1_sq = {24'h000000, ch1_abs} * {24'h000000, ch1_abs};
  wire [48:0] msq_diff = {1'b0, ch1_sq} - {1'b0, msq_r};
  wire [48:0] msq_step = {{`MWRP_RMS_SHIFT{msq_diff[48]}}, msq_diff[48:`MWRP_RMS_SHIFT]};
  // offset trim is scaled by 32768 in the squared domain, clamped at zero
  wire [48:0] os_ext = {{22{current_rms_offset_trim_r[11]}}, current_rms_offset_trim_r, 15'h0000};
  wire [48:0] corr_sum = {1'b0, msq_r} + os_ext;
  wire [47:0] corr_sq = corr_sum[48] ? 48'h000000000000 : corr_sum[47:0];

  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      msq_r <= 48'h000000000000;
      current_rms_result_r <= 24'h000000;
      rms_cnt_r <= 2'h0;
      ch1_last_r <= 24'h000000;
    end
    else
    begin
      rms_cnt_r <= rms_cnt_r + 2'h1;
      if (CH1_VALID_IN)
      begin
        ch1_last_r <= CH1_SAMPLE_IN;
        msq_r <= msq_r + msq_step[47:0];
      end
      // sqrt of mean square keeps the waveform lsb weight
      if (rms_cnt_r == `MWRP_RMS_DIV)
        current_rms_result_r <= mwrp_isqrt(corr_sq);
    end
  end

  // ==========================================================
  // waveform sampling rate divider and sample capture
  wire [10:0] rate_period = `MWRP_WAVE_DIV_MIN << rate_sel;
  wire rate_tick = (rate_cnt_r >= rate_period - 11'h001);
  wire wave_on = (src == `MWRP_SRC_CH1) || (src == `MWRP_SRC_CH2);
  wire new_sample = rate_tick && wave_on && waveform_sample_irq_enable_en;

  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      rate_cnt_r <= 11'h000;
      wave_r <= 24'h000000;
    end
    else
    begin
      rate_cnt_r <= rate_tick ? 11'h000 : rate_cnt_r + 11'h001;
      if (new_sample)
      begin
        if (src == `MWRP_SRC_CH1)
          wave_r <= ch1_last_r;
        else
          wave_r <= {{8{ch2_lpf_r[15]}}, ch2_lpf_r[15:0]};
      end
    end
  end

  // ==========================================================
  // read command decode: byte count and word per address
  reg [23:0] rd_word;
  reg [1:0] rd_len;
  always @*
  begin
    rd_word = 24'h000000;
    rd_len = 2'h1;
    case (ADDR_IN)
      `MWRP_ADDR_WAVEFORM: begin rd_word = wave_r; rd_len = 2'h3; end
      `MWRP_ADDR_MODE: begin rd_word = {8'h00, mode_r}; rd_len = 2'h2; end
      `MWRP_ADDR_IRQ_EN: begin rd_word = {8'h00, irq_en_r}; rd_len = 2'h2; end
      `MWRP_ADDR_STATUS: begin rd_word = {8'h00, status_r}; rd_len = 2'h2; end
      `MWRP_ADDR_RST_STATUS: begin rd_word = {8'h00, status_r}; rd_len = 2'h2; end
      `MWRP_ADDR_CH2_GAIN: rd_word = {21'h000000, gain_r};
      `MWRP_ADDR_CURRENT_RMS_RESULT: begin rd_word = current_rms_result_r; rd_len = 2'h3; end
      `MWRP_ADDR_CURRENT_RMS_OFFSET_TRIM: begin rd_word = {12'h000, current_rms_offset_trim_r}; rd_len = 2'h2; end
      default: rd_len = 2'h1; // unmapped reads return one zero byte
    endcase
  end

  // ==========================================================
  // status: sticky sample flag, set wins over read-reset clear
  wire rd_take = RD_IN && !BUSY_OUT;
  wire st_clr = rd_take && (ADDR_IN == `MWRP_ADDR_RST_STATUS);
  always @*
  begin
    status_nxt = status_r;
    if (st_clr)
      status_nxt = 16'h0000;
    if (new_sample)
      status_nxt[`MWRP_WAVEFORM_SAMPLE_IRQ_ENABLE_BIT] = 1'b1;
  end

  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      status_r <= 16'h0000;
      IRQ_N_OUT <= 1'b1;
    end
    else
    begin
      status_r <= status_nxt;
      IRQ_N_OUT <= ~|(status_nxt & irq_en_r);
    end
  end

  // ==========================================================
  // byte shifter: loads word, pushes msb first while buffer has room
  reg [23:0] sh_word_r;
  reg [1:0] sh_left_r;
  reg skid_valid_r;
  reg [7:0] skid_data_r;
  wire buf_in_ready = !skid_valid_r;
  wire push = (sh_left_r != 2'h0) && buf_in_ready;
  wire [7:0] push_byte = (sh_left_r == 2'h3) ? sh_word_r[23:16] :
                         (sh_left_r == 2'h2) ? sh_word_r[15:8] : sh_word_r[7:0];

  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      sh_word_r <= 24'h000000;
      sh_left_r <= 2'h0;
      BUSY_OUT <= 1'b0;
    end
    else if (rd_take)
    begin
      sh_word_r <= rd_word;
      sh_left_r <= rd_len;
      BUSY_OUT <= 1'b1;
    end
    else
    begin
      if (push)
        sh_left_r <= sh_left_r - 2'h1;
      // busy drops once the last byte has left the shifter
      BUSY_OUT <= (sh_left_r > 2'h1) || ((sh_left_r == 2'h1) && !push);
    end
  end

  // ==========================================================
  // two-entry output buffer: output register plus skid entry
  // a stalled receiver fills the skid, which then stalls the shifter
  wire out_free = !BYTE_VALID_OUT || BYTE_READY_IN;
  always @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      BYTE_VALID_OUT <= 1'b0;
      BYTE_DATA_OUT <= 8'h00;
      skid_valid_r <= 1'b0;
      skid_data_r <= 8'h00;
    end
    else if (out_free)
    begin
      if (skid_valid_r)
      begin
        BYTE_DATA_OUT <= skid_data_r;
        BYTE_VALID_OUT <= 1'b1;
        skid_valid_r <= 1'b0;
      end
      else
      begin
        BYTE_DATA_OUT <= push_byte;
        BYTE_VALID_OUT <= push;
      end
    end
    else if (push)
    begin
      skid_data_r <= push_byte;
      skid_valid_r <= 1'b1;
    end
  end

endmodule

// [mwrp_core_props.sv]
// Purpose: port-level checks for the waveform and rms path
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every mwrp_core instance
`timescale 1ns/1ns
`include "mwrp_consts.vh"
module mwrp_props (
  input wire CORE_CLK_IN,
  input wire RST_IN,
  input wire [23:0] CH1_SAMPLE_IN,
  input wire CH1_VALID_IN,
  input wire RD_IN,
  input wire [5:0] ADDR_IN,
  input wire BYTE_READY_IN,
  input wire [7:0] BYTE_DATA_OUT,
  input wire BYTE_VALID_OUT,
  input wire BUSY_OUT,
  input wire IRQ_N_OUT,
  input wire [23:0] CH1_MULT_OUT
);
// ==========================================================
// helper: clocks since the last interrupt fall, zero until the first
reg [10:0] gap_r;
always @(posedge CORE_CLK_IN)
begin
  if (RST_IN)
    gap_r <= 11'h000;
  else if ($fell(IRQ_N_OUT))
    gap_r <= 11'h001;
  else
    gap_r <= gap_r + {10'h000, (gap_r != 11'h000) && !(&gap_r)};
end
default clocking cb @(posedge CORE_CLK_IN); endclocking
default disable iff (RST_IN);
sequence rd_go;
  RD_IN && !BUSY_OUT;
endsequence
sequence clr_go;
  RD_IN && !BUSY_OUT && ADDR_IN == `MWRP_ADDR_RST_STATUS;
endsequence
// ==========================================================
// read port
chk_busy_rise: assert property (rd_go |=> BUSY_OUT)
  else $error("busy did not follow a taken read");
chk_first_byte: assert property (rd_go ##0 !BYTE_VALID_OUT |-> ##2 BYTE_VALID_OUT)
  else $error("first byte late");
chk_byte_hold: assert property (BYTE_VALID_OUT && !BYTE_READY_IN |=>
  BYTE_VALID_OUT && $stable(BYTE_DATA_OUT))
  else $error("byte dropped or changed under stall");
chk_busy_ends: assert property ($rose(BUSY_OUT) |-> ##[1:30] !BUSY_OUT)
  else $error("read never finished");
// ==========================================================
// interrupt and sample path
chk_irq_clear: assert property (clr_go |=> IRQ_N_OUT)
  else $error("interrupt not released by status read");
chk_irq_hold: assert property (!IRQ_N_OUT &&
  !(RD_IN && !BUSY_OUT && ADDR_IN == `MWRP_ADDR_RST_STATUS) |=> !IRQ_N_OUT)
  else $error("interrupt released without status read");
chk_irq_gap: assert property ($fell(IRQ_N_OUT) && gap_r != 11'h000 |-> gap_r >= 11'h080)
  else $error("samples faster than clock over 128");
chk_mult_copy: assert property (CH1_VALID_IN |=> CH1_MULT_OUT == $past(CH1_SAMPLE_IN))
  else $error("multiplier feed missed a sample");
endmodule
bind mwrp_core mwrp_props mwrp_props_i (.CORE_CLK_IN, .RST_IN, .CH1_SAMPLE_IN,
  .CH1_VALID_IN, .RD_IN, .ADDR_IN, .BYTE_READY_IN, .BYTE_DATA_OUT, .BYTE_VALID_OUT,
  .BUSY_OUT, .IRQ_N_OUT, .CH1_MULT_OUT);

// [mwrp_host_model.sv]
// Purpose: byte receiver standing in for the host controller
// Assumes: accepts a byte on any edge with valid and ready high
// Notes: slow mode stalls in a pseudo-random pattern of short runs
`timescale 1ns/1ns
module mwrp_host_model (
  input wire clk_in,
  input wire rst_in,
  input wire slow_in,
  output reg ready_out
);
reg [7:0] lfsr_r;
// ==========================================================
// stall pattern: never more than a few idle clocks in a row
always @(posedge clk_in)
begin
  if (rst_in)
  begin
    lfsr_r <= 8'h5a;
    ready_out <= 1'b0;
  end
  else
  begin
    lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    ready_out <= !slow_in || lfsr_r[0] || lfsr_r[1];
  end
end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the waveform and rms path
// Assumes: 10 MHz clock, converter pulses every fourth clock
// Notes: read bytes are matched against a queue of expected values
`timescale 1ns/1ns
`include "mwrp_consts.vh"
module tb_top;
reg clk = 1'b0;
reg rst = 1'b1;
reg c1v = 1'b0;
reg c2v = 1'b0;
reg wr = 1'b0;
reg rd = 1'b0;
reg slow = 1'b0;
reg [1:0] ph = 2'h0;
reg [5:0] addr = 6'h00;
reg [15:0] wd = 16'h0000;
reg [15:0] c2s = 16'h0000;
reg [23:0] c1s = 24'h000000;
wire rdy, bv, busy, irq_n;
wire [7:0] bd;
wire [15:0] c2m;
integer n_mismatch = 0;
integer check_count = 0;
integer seed = 88;
integer cyc = 0;
integer hi_c = 0;
integer i, t, t1, r;
reg [7:0] exp_q[$];
mwrp_core mwrp_core_i (.CORE_CLK_IN(clk), .RST_IN(rst), .CH1_SAMPLE_IN(c1s),
  .CH1_VALID_IN(c1v), .CH2_SAMPLE_IN(c2s), .CH2_VALID_IN(c2v), .WR_IN(wr), .RD_IN(rd),
  .ADDR_IN(addr), .WDATA_IN(wd), .BYTE_READY_IN(rdy), .BYTE_DATA_OUT(bd),
  .BYTE_VALID_OUT(bv), .BUSY_OUT(busy), .IRQ_N_OUT(irq_n), .CH2_MULT_OUT(c2m),
  .CH1_MULT_OUT());
mwrp_host_model mwrp_host_model_i (.clk_in(clk), .rst_in(rst), .slow_in(slow),
  .ready_out(rdy));
initial forever #50 clk = ~clk;
// ==========================================================
// converter pacing and a record of the last clock the interrupt was idle
always @(posedge clk)
begin
  ph <= ph + 2'h1;
  c1v <= (ph == 2'h3);
  c2v <= (ph == 2'h3);
  cyc <= cyc + 1;
  if (irq_n === 1'b1)
    hi_c <= cyc;
end
// every accepted byte takes the oldest note; an empty queue never matches
always @(posedge clk)
  if (bv === 1'b1 && rdy === 1'b1)
    cmp({16'h0000, bd}, {16'h0000, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx});
task cmp(input [23:0] a, input [23:0] e);
begin
  check_count = check_count + 1;
  if (a !== e)
  begin
    n_mismatch = n_mismatch + 1;
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
  end
end
endtask
task wrr(input [5:0] a, input [15:0] d);
begin
  @(posedge clk);
  wr <= 1'b1;
  addr <= a;
  wd <= d;
  @(posedge clk);
  wr <= 1'b0;
end
endtask
// notes go in first so the monitor never sees a byte before its note
task rdr(input [5:0] a, input integer n, input [23:0] v);
begin
  for (i = n - 1; i >= 0; i = i - 1)
    exp_q.push_back(v[8 * i +: 8]);
  @(negedge clk);
  while (busy !== 1'b0)
    @(negedge clk);
  @(posedge clk);
  rd <= 1'b1;
  addr <= a;
  @(posedge clk);
  rd <= 1'b0;
  t = 0;
  while (exp_q.size() != 0 && t < 200)
  begin
    @(negedge clk);
    t = t + 1;
  end
  if (t == 200)
    n_mismatch = n_mismatch + 1;
end
endtask
task wfall;
begin
  t = 0;
  while (irq_n !== 1'b0 && t < 3000)
  begin
    @(negedge clk);
    t = t + 1;
  end
  if (t == 3000)
    n_mismatch = n_mismatch + 1;
end
endtask
task test_done;
begin
  $display("checks %0d mismatches %0d", check_count, n_mismatch);
  if (n_mismatch == 0 && check_count > 0)
    $display("Result: passed");
  else
    $display("Result: failed");
  $finish;
end
endtask
// ==========================================================
// main sequence
initial
begin
  repeat (10) @(posedge clk);
  rst <= 1'b0;
  rdr(`MWRP_ADDR_MODE, 2, {8'h00, `MWRP_MODE_RST});
  wrr(`MWRP_ADDR_CURRENT_RMS_OFFSET_TRIM, 16'hfabc);
  rdr(`MWRP_ADDR_CURRENT_RMS_OFFSET_TRIM, 2, 24'h000abc);
  // zero input so far: result is sqrt(512 * 32768) = 4096 after the next refresh
  wrr(`MWRP_ADDR_CURRENT_RMS_OFFSET_TRIM, 16'h0200);
  repeat (8) @(posedge clk);
  rdr(`MWRP_ADDR_CURRENT_RMS_RESULT, 3, 24'h001000);
  rdr(6'h3f, 1, 24'h000000);
  // codes above 4 must act as gain 16
  for (r = 0; r < 6; r = r + 1)
  begin
    wrr(`MWRP_ADDR_CH2_GAIN, r[15:0]);
    c2s <= 16'($random(seed)) & 16'h07ff;
    repeat (8) @(posedge clk);
    cmp({8'h00, c2m}, {8'h00, c2s << ((r > 4) ? 4 : r)});
    rdr(`MWRP_ADDR_CH2_GAIN, 1, r[23:0]);
  end
  c1s <= 24'($random(seed));
  wrr(`MWRP_ADDR_IRQ_EN, 16'h0008);
  rdr(`MWRP_ADDR_IRQ_EN, 2, 24'h000008);
  // two clears before the timed fall so the measured gap lies wholly inside the new rate
  for (r = 0; r < 4; r = r + 1)
  begin
    wrr(`MWRP_ADDR_MODE, {1'b0, `MWRP_SRC_CH1, r[1:0], 11'h00c});
    wfall;
    rdr(`MWRP_ADDR_RST_STATUS, 2, 24'h000008);
    wfall;
    t1 = hi_c;
    rdr(`MWRP_ADDR_RST_STATUS, 2, 24'h000008);
    wfall;
    cmp(24'(hi_c - t1), 24'h000080 << r);
    rdr(`MWRP_ADDR_WAVEFORM, 3, c1s);
    rdr(`MWRP_ADDR_RST_STATUS, 2, 24'h000008);
    slow <= ~r[0];
  end
  wrr(`MWRP_ADDR_MODE, {1'b0, `MWRP_SRC_CH2, 13'h000c});
  wfall;
  cmp({23'h000000, irq_n}, 24'h000000);
  // the plain status address reports without clearing, so the line stays low
  rdr(`MWRP_ADDR_STATUS, 2, 24'h000008);
  cmp({23'h000000, irq_n}, 24'h000000);
  rdr(`MWRP_ADDR_RST_STATUS, 2, 24'h000008);
  cmp({23'h000000, irq_n}, 24'h000001);
  test_done;
end
// watchdog: the whole sequence needs about a fifth of this span
initial
begin
  #3000000;
  n_mismatch = n_mismatch + 1;
  test_done;
end
endmodule
